// ---- core/adc_output_formatter.v ----
// output side of the eight-channel converter: gain, coding, serialiser, bit clock
// assumes samples arrive on clk_sys_i; the sample clock pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_consts.vh"
module adc_output_formatter #(
    parameter CHANNELS = 8,
    parameter QTR_CYCLES = 1
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    output reg reg_rvalid_o,
    input wire sample_valid_i,
    output wire sample_ready_o,
    input wire [CHANNELS*13-1:0] sample_data_i,
    input wire sample_clock_i,
    output reg [CHANNELS-1:0] data_lane_o,
    output reg frame_clock_out_pos_o,
    output reg bit_clock_o,
    output reg [5:0] full_scale_trim_code_o
);
    localparam WW = CHANNELS * 14;
    localparam S_IDLE = 1'b0;
    localparam S_SEND = 1'b1;

    reg [15:0] gain_lo_reg;
    reg [15:0] gain_hi_reg;
    reg [1:0] phase_reg;
    reg twos_reg;
    reg msb_first_reg;
    reg sdr_reg;
    reg fall_sdr_reg;
    reg len14_reg;
    reg advance_reg;
    reg delay_reg;

    reg sclk_meta_reg;
    reg sclk_sync_reg;
    reg sclk_prev_reg;
    reg frame_pend_reg;

    reg [1:0] qtr_reg;
    reg [7:0] qdiv_reg;
    reg ddr_clk_reg;
    reg state_reg;
    reg [3:0] bit_idx_reg;
    reg [WW-1:0] word_reg;
    reg [CHANNELS-1:0] lane_s0_reg;
    reg [CHANNELS-1:0] lane_s1_reg;
    reg [CHANNELS-1:0] lane_s2_reg;
    reg [2:0] frame_stage_reg;

    wire [CHANNELS*4-1:0] gain_codes;
    wire [CHANNELS*13-1:0] gained;
    reg [WW-1:0] fmt_word;
    wire buf_valid;
    wire [WW-1:0] buf_data;
    wire [3:0] word_len = len14_reg ? `WORD_LEN_LONG : `WORD_LEN_SHORT;
    wire qtick = (qdiv_reg == QTR_CYCLES - 1);
    wire win_end = qtick && (qtr_reg == 2'h3);
    wire edge_seen = sclk_sync_reg & ~sclk_prev_reg;
    wire start_word = win_end && (state_reg == S_IDLE) && frame_pend_reg;
    wire buf_pop = start_word && buf_valid;

    // each channel's own field, laid out as in the two gain registers
    assign gain_codes = {gain_hi_reg[3:0], gain_hi_reg[7:4], gain_hi_reg[11:8],
                         gain_hi_reg[15:12], gain_lo_reg};

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_ch
            gain_stage u_gain (
                .code_i(gain_codes[ch*4 +: 4]),
                .sample_i(sample_data_i[ch*13 +: 13]),
                .sample_o(gained[ch*13 +: 13])
            );
        end
    endgenerate

    // coding and word length applied on entry, so a buffered word keeps its format
    integer i;
    reg [12:0] coded;
    always @* begin
        coded = 13'h0000;
        fmt_word = {WW{1'b0}};
        for (i = 0; i < CHANNELS; i = i + 1) begin
            coded = gained[i*13 +: 13];
            coded[12] = coded[12] ^ twos_reg;
            if (len14_reg) begin
                fmt_word[i*14 +: 14] = {coded, 1'b0};
            end else begin
                fmt_word[i*14 +: 14] = {2'b00, coded[12:1]};
            end
        end
    end

    // a stalled serialiser holds words here and pushes back on the source
    two_entry_buffer #(
        .WIDTH(WW)
    ) u_buf (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(sample_ready_o),
        .in_data_i(fmt_word),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop),
        .out_data_o(buf_data)
    );

    // register port
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gain_lo_reg <= {4{`GAIN_RESET}};
            gain_hi_reg <= {4{`GAIN_RESET}};
            phase_reg <= `PHASE_RESET;
            twos_reg <= 1'b0;
            msb_first_reg <= 1'b0;
            sdr_reg <= 1'b0;
            fall_sdr_reg <= 1'b0;
            len14_reg <= 1'b0;
            advance_reg <= 1'b0;
            delay_reg <= 1'b0;
            full_scale_trim_code_o <= `TRIM_RESET;
            reg_rdata_o <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `ADDR_GAIN_LO: gain_lo_reg <= reg_wdata_i;
                    `ADDR_GAIN_HI: gain_hi_reg <= reg_wdata_i;
                    `ADDR_PHASE: phase_reg <= reg_wdata_i[`PHASE_LSB +: 2];
                    `ADDR_FORMAT: begin
                        twos_reg <= reg_wdata_i[`FMT_TWOS_BIT];
                        msb_first_reg <= reg_wdata_i[`FMT_MSB_FIRST_BIT];
                        sdr_reg <= reg_wdata_i[`FMT_SDR_BIT];
                        fall_sdr_reg <= reg_wdata_i[`FMT_FALL_SDR_BIT];
                    end
                    `ADDR_WORD: begin
                        // a length change mid-stream is only safe under power-down
                        len14_reg <= reg_wdata_i[`WORD_LEN14_BIT];
                        advance_reg <= reg_wdata_i[`WORD_ADVANCE_BIT];
                        delay_reg <= reg_wdata_i[`WORD_DELAY_BIT];
                    end
                    `ADDR_TRIM: full_scale_trim_code_o <= reg_wdata_i[5:0];
                    default: ;
                endcase
            end
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ADDR_GAIN_LO: reg_rdata_o <= gain_lo_reg;
                    `ADDR_GAIN_HI: reg_rdata_o <= gain_hi_reg;
                    `ADDR_PHASE: reg_rdata_o <= {9'h000, phase_reg, 5'h00};
                    `ADDR_FORMAT: reg_rdata_o <= {2'h0, fall_sdr_reg, 8'h00, sdr_reg,
                                                  msb_first_reg, twos_reg, 2'h0};
                    `ADDR_WORD: reg_rdata_o <= {10'h000, delay_reg, advance_reg,
                                                2'h0, len14_reg, 1'b0};
                    `ADDR_TRIM: reg_rdata_o <= {10'h000, full_scale_trim_code_o};
                    default: reg_rdata_o <= 16'h0000;
                endcase
            end
        end
    end

    // sample clock pin: two flops, then edge detect on the second
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            frame_pend_reg <= 1'b0;
        end else if (ce_i) begin
            sclk_meta_reg <= sample_clock_i;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
            // an edge during a running word is dropped, the word is not cut
            if (edge_seen && state_reg == S_IDLE) begin
                frame_pend_reg <= 1'b1;
            end else if (start_word) begin
                frame_pend_reg <= 1'b0;
            end
        end
    end

    // free-running window of four quarters; the bit clock never sees the shift
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            qdiv_reg <= 8'h00;
            qtr_reg <= 2'h0;
            ddr_clk_reg <= 1'b0;
            bit_clock_o <= 1'b0;
        end else if (ce_i) begin
            if (qtick) begin
                qdiv_reg <= 8'h00;
                qtr_reg <= qtr_reg + 2'h1;
                // ddr toggles once a window at the quarter the phase picks
                if (qtr_reg + 2'h1 == phase_reg) begin
                    ddr_clk_reg <= ~ddr_clk_reg;
                end
            end else begin
                qdiv_reg <= qdiv_reg + 8'h01;
            end
            if (sdr_reg) begin
                // one full period per window, chosen edge at mid-window
                bit_clock_o <= (qtr_reg[1] ^ fall_sdr_reg);
            end else begin
                bit_clock_o <= ddr_clk_reg;
            end
        end
    end

    // serialiser: one bit per window per lane
    integer k;
    reg [CHANNELS-1:0] lane_bits;
    reg [3:0] sel;
    always @* begin
        lane_bits = {CHANNELS{1'b0}};
        sel = 4'h0;
        // lsb leads unless msb-first is set
        if (msb_first_reg) begin
            sel = word_len - 4'h1 - bit_idx_reg;
        end else begin
            sel = bit_idx_reg;
        end
        for (k = 0; k < CHANNELS; k = k + 1) begin
            lane_bits[k] = word_reg[k*14 + sel];
        end
    end

    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= S_IDLE;
            bit_idx_reg <= 4'h0;
            word_reg <= {WW{1'b0}};
            lane_s0_reg <= {CHANNELS{1'b0}};
            lane_s1_reg <= {CHANNELS{1'b0}};
            lane_s2_reg <= {CHANNELS{1'b0}};
            frame_stage_reg <= 3'h0;
        end else if (ce_i) begin
            if (start_word) begin
                state_reg <= S_SEND;
                bit_idx_reg <= 4'h0;
                // an empty buffer repeats the last word rather than stalling the frame
                if (buf_valid) begin
                    word_reg <= buf_data;
                end
            end else if (win_end && state_reg == S_SEND) begin
                if (bit_idx_reg == word_len - 4'h1) begin
                    state_reg <= S_IDLE;
                    bit_idx_reg <= 4'h0;
                end else begin
                    bit_idx_reg <= bit_idx_reg + 4'h1;
                end
            end
            if (win_end) begin
                // three-window pipe: stage 0 early, 1 nominal, 2 late
                if (state_reg == S_SEND) begin
                    lane_s0_reg <= lane_bits;
                    frame_stage_reg[0] <= (bit_idx_reg < {1'b0, word_len[3:1]});
                end else begin
                    lane_s0_reg <= {CHANNELS{1'b0}};
                    frame_stage_reg[0] <= 1'b0;
                end
                lane_s1_reg <= lane_s0_reg;
                lane_s2_reg <= lane_s1_reg;
                frame_stage_reg[2:1] <= frame_stage_reg[1:0];
            end
        end
    end

    // output taps; advance and delay together fall back to nominal
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_lane_o <= {CHANNELS{1'b0}};
            frame_clock_out_pos_o <= 1'b0;
        end else if (ce_i) begin
            if (advance_reg && !delay_reg) begin
                data_lane_o <= lane_s0_reg;
                frame_clock_out_pos_o <= frame_stage_reg[0];
            end else if (delay_reg && !advance_reg) begin
                data_lane_o <= lane_s2_reg;
                frame_clock_out_pos_o <= frame_stage_reg[2];
            end else begin
                data_lane_o <= lane_s1_reg;
                frame_clock_out_pos_o <= frame_stage_reg[1];
            end
        end
    end
endmodule
`default_nettype wire

// ---- shared/adc_fmt_consts.vh ----
// constants for the output formatter: register offsets, fields, reset values
// assumes inclusion by bare name from the core design files
`ifndef ADC_FMT_CONSTS_VH
`define ADC_FMT_CONSTS_VH

`define ADDR_GAIN_LO 8'h2a
`define ADDR_GAIN_HI 8'h2b
`define ADDR_PHASE 8'h42
`define ADDR_FORMAT 8'h46
`define ADDR_WORD 8'h53
`define ADDR_TRIM 8'h55

`define GAIN_W 4
`define GAIN_RESET 4'h0
`define GAIN_MAX 4'hc
`define PHASE_LSB 5
`define PHASE_RESET 2'h2
`define FMT_TWOS_BIT 2
`define FMT_MSB_FIRST_BIT 3
`define FMT_SDR_BIT 4
`define FMT_FALL_SDR_BIT 13
`define WORD_LEN14_BIT 1
`define WORD_ADVANCE_BIT 4
`define WORD_DELAY_BIT 5
`define TRIM_W 6
`define TRIM_RESET 6'h20

`define SAMPLE_W 13
`define WORD_W 14
`define WORD_LEN_SHORT 4'hc
`define WORD_LEN_LONG 4'he
`define CODE_MIN 13'h0000
`define CODE_MAX 13'h1fff
`define CODE_MID 14'h1000
`define GAIN_FRAC 12

`endif

// ---- core/gain_stage.v ----
// one channel of digital gain on a 13-bit offset-binary sample, with saturation
// assumes a code already below 13; higher codes fall back to unity
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_consts.vh"
module gain_stage (
    input wire [`GAIN_W-1:0] code_i,
    input wire [`SAMPLE_W-1:0] sample_i,
    output reg [`SAMPLE_W-1:0] sample_o
);
    reg [15:0] factor;
    reg signed [13:0] centered;
    reg signed [30:0] product;
    reg signed [18:0] scaled;
    always @* begin
        // 1 db steps as q12 factors
        case (code_i)
            4'h1: factor = 16'h11f4;
            4'h2: factor = 16'h1425;
            4'h3: factor = 16'h169a;
            4'h4: factor = 16'h195c;
            4'h5: factor = 16'h1c74;
            4'h6: factor = 16'h1fed;
            4'h7: factor = 16'h23d2;
            4'h8: factor = 16'h2831;
            4'h9: factor = 16'h2d18;
            4'ha: factor = 16'h3299;
            4'hb: factor = 16'h38c5;
            4'hc: factor = 16'h3fb2;
            default: factor = 16'h1000;
        endcase
        // purely digital, on the converted code
        centered = $signed({1'b0, sample_i}) - $signed(`CODE_MID);
        product = centered * $signed({1'b0, factor});
        scaled = product[30:12] + $signed({5'h00, `CODE_MID});
        // clamp instead of wrapping
        if (scaled < 0) begin
            sample_o = `CODE_MIN;
        end else if (scaled > $signed({6'h00, `CODE_MAX})) begin
            sample_o = `CODE_MAX;
        end else begin
            sample_o = scaled[`SAMPLE_W-1:0];
        end
    end
endmodule
`default_nettype wire

// ---- core/two_entry_buffer.v ----
// two-entry valid/ready buffer; in_ready_o and out_valid_o are registered
// assumes one clock, one async reset and a common clock enable
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
    parameter WIDTH = 112
) (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire in_valid_i,
    output reg in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output reg out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg wr_ptr_reg;
    reg rd_ptr_reg;
    reg [1:0] count_reg;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire [1:0] count_next = count_reg + {1'b0, push} - {1'b0, pop};
    assign out_data_o = mem_reg[rd_ptr_reg];
    always @(posedge clk_sys_i) begin
        if (ce_i && push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end else if (ce_i) begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_next;
            in_ready_o <= (count_next != 2'h2);
            out_valid_o <= (count_next != 2'h0);
        end
    end
endmodule
`default_nettype wire

// ---- verif/adc_fmt_assertions.sv ----
// checker for register answers, trim, bit clock and frame clock of the formatter
// assumes QTR_CYCLES of 1 wherever bit clock windows are spelled out
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_consts.vh"
module adc_fmt_assertions #(
    parameter CHANNELS = 8,
    parameter QTR_CYCLES = 1
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic frame_clock_out_pos_o,
    input wire logic bit_clock_o,
    input wire logic [5:0] full_scale_trim_code_o
);
    localparam int WIN = 4 * QTR_CYCLES;
    logic sdr_reg;
    logic [3:0] age_reg;
    logic [7:0] hi_reg;
    logic [7:0] gap_reg;
    wire logic wr = reg_wr_i && ce_i;
    wire logic trim_wr = wr && reg_addr_i == `ADDR_TRIM;
    // mode or phase writes disturb the bit clock, so its checks wait until settled
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sdr_reg <= 1'b0;
            age_reg <= 4'h0;
            hi_reg <= 8'h00;
            gap_reg <= 8'hff;
        end else begin
            if (wr && reg_addr_i == `ADDR_FORMAT)
                sdr_reg <= reg_wdata_i[`FMT_SDR_BIT];
            if (wr && (reg_addr_i == `ADDR_FORMAT || reg_addr_i == `ADDR_PHASE))
                age_reg <= 4'h0;
            else if (age_reg != 4'hf)
                age_reg <= age_reg + 4'h1;
            hi_reg <= frame_clock_out_pos_o ? hi_reg + 8'h01 : 8'h00;
            if (frame_clock_out_pos_o && hi_reg == 8'h00)
                gap_reg <= 8'h01;
            else if (gap_reg != 8'hff)
                gap_reg <= gap_reg + 8'h01;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_read_answered: assert property (reg_rd_i && ce_i |=> reg_rvalid_o)
        else $error("read not answered next cycle");
    a_rvalid_has_read: assert property (reg_rvalid_o |-> $past(reg_rd_i && ce_i))
        else $error("read valid without a read");
    a_rdata_stable: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_trim_follows: assert property (trim_wr |=> full_scale_trim_code_o == $past(reg_wdata_i[5:0]))
        else $error("trim code not taken from write");
    a_trim_held: assert property (!trim_wr |=> $stable(full_scale_trim_code_o))
        else $error("trim code moved without its write");
    // both look backwards, so a mode or phase write just after an edge cannot trip them
    a_ddr_bitclk_window: assert property (age_reg == 4'hf && !sdr_reg && $changed(bit_clock_o)
        |-> $past(bit_clock_o, 1) == $past(bit_clock_o, 2)
            && $past(bit_clock_o, 2) == $past(bit_clock_o, 3)
            && $past(bit_clock_o, 3) == $past(bit_clock_o, 4)
            && $past(bit_clock_o, 4) != $past(bit_clock_o, 5))
        else $error("ddr bit clock not one edge per window");
    a_sdr_bitclk_rate: assert property (age_reg == 4'hf && sdr_reg && $rose(bit_clock_o)
        |-> !$past(bit_clock_o, 2) && $past(bit_clock_o, 3) && $past(bit_clock_o, 4)
            && !$past(bit_clock_o, 5))
        else $error("sdr bit clock not one period per window");
    a_frame_half_word: assert property ($fell(frame_clock_out_pos_o)
        |-> hi_reg == 6 * WIN || hi_reg == 7 * WIN)
        else $error("frame clock high time not half a word");
    a_frame_spacing: assert property ($rose(frame_clock_out_pos_o) |-> gap_reg >= 12 * WIN)
        else $error("frames closer than one word");
    c_frame: cover property ($rose(frame_clock_out_pos_o));
    c_sdr: cover property (sdr_reg && $rose(bit_clock_o));
    c_trim: cover property (trim_wr);
endmodule
bind adc_output_formatter adc_fmt_assertions #(
    .CHANNELS(CHANNELS),
    .QTR_CYCLES(QTR_CYCLES)
) i_adc_fmt_assertions (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .frame_clock_out_pos_o(frame_clock_out_pos_o),
    .bit_clock_o(bit_clock_o),
    .full_scale_trim_code_o(full_scale_trim_code_o)
);
`default_nettype wire

// ---- verif/lane_receiver.sv ----
// receiving logic model: takes each lane once per bit window after a frame rise
// assumes an idle window between words; back-to-back words would be missed
`timescale 1ns/1ps
`default_nettype none
module lane_receiver #(
    parameter QTR_CYCLES = 1
) (
    input wire logic clk_sys_i,
    input wire logic frame_clock_i,
    input wire logic [7:0] lanes_i,
    output logic [111:0] words_o,
    output logic [3:0] len_o,
    output logic [7:0] frames_o
);
    int n;
    int h;
    // one mid-window sample per bit, so no bit clock edge is relied on
    // samples on the falling clock, clear of the edge that moves the lanes
    initial begin
        frames_o = 8'h00;
        forever begin
            @(posedge frame_clock_i);
            n = 0;
            h = 0;
            words_o = '0;
            repeat (2 * QTR_CYCLES) @(negedge clk_sys_i);
            while (h == n || n < 2 * h) begin
                if (frame_clock_i)
                    h = h + 1;
                for (int c = 0; c < 8; c++)
                    words_o[c * 14 + n] = lanes_i[c];
                n = n + 1;
                repeat (4 * QTR_CYCLES) @(negedge clk_sys_i);
            end
            len_o = 4'(n);
            frames_o = frames_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// bench for the formatter: register port, gains, coding, buffer and serial lanes
// assumes the lane receiver model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_consts.vh"
module tb_top;
    localparam logic [103:0] SMP_A = {13'h1555, 13'h0001, 13'h1fff, 13'h0800,
        13'h1800, 13'h1200, 13'h10c8, 13'h0abc};
    localparam logic [103:0] EXP_A = {13'h1555, 13'h0001, 13'h1fff, 13'h0000,
        13'h1fff, 13'h17f6, 13'h118f, 13'h0abc};
    localparam logic [103:0] SMP_B = {13'h0f0f, SMP_A[90:13], 13'h1234};
    localparam logic [103:0] EXP_B = {13'h0f0f, EXP_A[90:13], 13'h1234};
    // phase, format, word timing; the last sets both shift bits, read as nominal
    localparam logic [47:0] CFG [4] = '{48'h0040_0000_0000, 48'h0000_0004_0022,
        48'h0020_0018_0010, 48'h0060_201c_0032};
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic sample_valid_i = 1'b0;
    logic [103:0] sample_data_i = '0;
    logic sample_clock_i = 1'b0;
    logic sclk_run = 1'b0;
    logic [15:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic sample_ready_o;
    logic [7:0] data_lane_o;
    logic frame_clock_out_pos_o;
    logic bit_clock_o;
    logic [5:0] full_scale_trim_code_o;
    logic [111:0] rx_words;
    logic [3:0] rx_len;
    logic [7:0] rx_frames;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    adc_output_formatter #(.CHANNELS(8), .QTR_CYCLES(1)) i_adc_output_formatter (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
        .sample_data_i(sample_data_i), .sample_clock_i(sample_clock_i),
        .data_lane_o(data_lane_o), .frame_clock_out_pos_o(frame_clock_out_pos_o),
        .bit_clock_o(bit_clock_o), .full_scale_trim_code_o(full_scale_trim_code_o));
    lane_receiver #(.QTR_CYCLES(1)) i_lane_receiver (
        .clk_sys_i(clk_sys_i), .frame_clock_i(frame_clock_out_pos_o),
        .lanes_i(data_lane_o), .words_o(rx_words), .len_o(rx_len), .frames_o(rx_frames));
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // 8 MSPS, faster than the serialiser's word rate, so some edges land in running words and are dropped; stands low while stopped
    initial begin
        #1.3;
        forever begin
            #62.5;
            sample_clock_i = sclk_run ? ~sample_clock_i : 1'b0;
        end
    end
    task automatic tally_and_finish;
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            tally_and_finish;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_sys_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk_sys_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
    endtask
    task automatic push(input logic [103:0] w);
        @(negedge clk_sys_i);
        sample_valid_i = 1'b1;
        sample_data_i = w;
        do @(posedge clk_sys_i); while (sample_ready_o !== 1'b1);
        @(negedge clk_sys_i);
        sample_valid_i = 1'b0;
        sample_data_i = ~w;
    endtask
    function automatic logic [13:0] ser(input logic [12:0] s, input logic [15:0] f,
        input logic [15:0] wd);
        logic [12:0] v;
        logic [13:0] w;
        logic [13:0] r;
        int len;
        len = wd[`WORD_LEN14_BIT] ? 14 : 12;
        v = f[`FMT_TWOS_BIT] ? s ^ 13'h1000 : s;
        w = wd[`WORD_LEN14_BIT] ? {v, 1'b0} : {2'b00, v[12:1]};
        r = w;
        if (f[`FMT_MSB_FIRST_BIT])
            for (int i = 0; i < 14; i++)
                r[i] = (i < len) ? w[len - 1 - i] : 1'b0;
        return r;
    endfunction
    task automatic t_reset_values;
        logic [15:0] d;
        logic [7:0] adr [7] = '{8'h2a, 8'h2b, 8'h42, 8'h46, 8'h53, 8'h55, 8'h10};
        logic [15:0] exp [7] = '{16'h0000, 16'h0000, 16'h0040, 16'h0000, 16'h0000,
            16'h0020, 16'h0000};
        check({10'h000, full_scale_trim_code_o}, 16'h0020);
        reg_wr(8'h10, 16'hffff);
        for (int i = 0; i < 7; i++) begin
            reg_rd(adr[i], d);
            check(d, exp[i]);
        end
    endtask
    task automatic t_gain_and_trim;
        logic [15:0] d;
        reg_wr(`ADDR_GAIN_LO, 16'hcc60);
        reg_wr(`ADDR_GAIN_HI, 16'hc000);
        reg_wr(`ADDR_TRIM, 16'hffff);
        reg_rd(`ADDR_GAIN_LO, d);
        check(d, 16'hcc60);
        reg_rd(`ADDR_GAIN_HI, d);
        check(d, 16'hc000);
        reg_rd(`ADDR_TRIM, d);
        check(d, 16'h003f);
        check({10'h000, full_scale_trim_code_o}, 16'h003f);
    endtask
    // no power-down pin here, so word length only changes with the link idle
    task automatic t_stream(input logic [47:0] c);
        logic [15:0] d;
        logic [7:0] base;
        logic [103:0] e;
        logic prev;
        int rises;
        realtime t0;
        reg_wr(`ADDR_PHASE, c[47:32]);
        reg_wr(`ADDR_FORMAT, c[31:16]);
        reg_wr(`ADDR_WORD, c[15:0]);
        reg_rd(`ADDR_PHASE, d);
        check(d, c[47:32]);
        reg_rd(`ADDR_FORMAT, d);
        check(d, c[31:16]);
        reg_rd(`ADDR_WORD, d);
        check(d, c[15:0]);
        push(SMP_A);
        push(SMP_B);
        @(negedge clk_sys_i);
        check({15'h0000, sample_ready_o}, 16'h0000);
        base = rx_frames;
        sclk_run = 1'b1;
        // pin edge to first frame rise is three windows nominal, one less or more when shifted
        d = (c[`WORD_DELAY_BIT] ^ c[`WORD_ADVANCE_BIT]) ?
            {13'h0000, c[`WORD_DELAY_BIT], c[`WORD_ADVANCE_BIT], 1'b0} : 16'h0003;
        @(posedge sample_clock_i);
        t0 = $realtime;
        @(posedge frame_clock_out_pos_o);
        check(16'(int'($realtime - t0) / 20), d);
        // the third frame finds the buffer empty and repeats the last word
        for (int f = 1; f <= 3; f++) begin
            wait (rx_frames == base + 8'(f));
            e = (f == 1) ? EXP_A : EXP_B;
            check({12'h000, rx_len}, c[`WORD_LEN14_BIT] ? 16'h000e : 16'h000c);
            for (int ch = 0; ch < 8; ch++)
                check({2'b00, rx_words[ch * 14 +: 14]},
                    {2'b00, ser(e[ch * 13 +: 13], c[31:16], c[15:0])});
        end
        sclk_run = 1'b0;
        rises = 0;
        prev = bit_clock_o;
        repeat (40) begin
            @(negedge clk_sys_i);
            if (bit_clock_o && !prev)
                rises++;
            prev = bit_clock_o;
        end
        check(16'(rises), c[16 + `FMT_SDR_BIT] ? 16'h000a : 16'h0005);
        repeat (200) @(negedge clk_sys_i);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        t_reset_values;
        t_gain_and_trim;
        for (int i = 0; i < 4; i++)
            t_stream(CFG[i]);
        tally_and_finish;
    end
endmodule
`default_nettype wire
